// ---- inc/dss_pkg.sv ----
package dss_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int CTRL_CYCLE_NS = 100_000;
    localparam int CTRL_CYCLES = (CTRL_CYCLE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    localparam int TICK_W = $clog2(CTRL_CYCLES);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CTRL_CYCLES - 1);
    localparam int DELAY_UNIT_MS = 10;
    localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_MS * 1_000_000
                                       / CLK_PERIOD_NS;
    localparam int DROP_W = 13;
    localparam logic [DROP_W-1:0] DROPOUT_MAX = 13'h1770;

    // ************************************************************
    // sizes and functions
    // ************************************************************
    localparam int N_TERM = 6;
    localparam int SP_W = 16;
    localparam int SUM_W = SP_W + 4;
    localparam int NF = 10;
    localparam int FI_SDB = 0;
    localparam int FI_EN = 1;
    localparam int FI_OSC = 2;
    localparam int FI_INCH = 3;
    localparam int FI_INCHB = 4;
    localparam int FI_CRAWL = 5;
    localparam int FI_CRAWLB = 6;
    localparam int FI_FIX = 7;
    localparam int FI_FIXB = 8;
    localparam int FI_SUP = 9;
    localparam logic [4:0] FC_TAB [NF] = '{5'h02, 5'h0B, 5'h0C, 5'h0D,
        5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13};
    localparam int N_CWSP = 7;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] FUNC_CFG_OFS = 8'h00;
    localparam logic [7:0] CTRL_WORD_OFS = 8'h04;
    localparam logic [7:0] CFG_OFS = 8'h08;
    localparam logic [7:0] DROPOUT_OFS = 8'h0C;
    localparam logic [7:0] DSP_BASE = 8'h10;
    localparam logic [7:0] DSP_END = 8'h28;
    localparam logic [7:0] CWSP_BASE = 8'h28;
    localparam logic [7:0] CWSP_END = 8'h44;
    localparam logic [7:0] STATUS_OFS = 8'h44;
    localparam logic [7:0] RAMP_OFS = 8'h48;
    localparam logic [7:0] TECH_OFS = 8'h4C;
    localparam logic [29:0] FUNC_CFG_RST = 30'h0000_0000;
    localparam logic [NF-1:0] CTRL_WORD_RST = 10'h003;
    localparam logic [DROP_W-1:0] DROPOUT_RST = 13'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACT = 2'b01,
        ST_DOWN = 2'b11,
        ST_DELAY = 2'b10
    } dss_seq_t;
endpackage

// ---- inc/dss_sel_if.sv ----
`timescale 1ns/1ps
interface dss_sel_if;
    import dss_pkg::*;
    logic [N_TERM-1:0] term;
    logic [N_TERM*5-1:0] func;
    logic [N_TERM-1:0] asg [NF];
    logic [N_TERM-1:0] act [NF];
    modport dec (input term, input func, output asg, output act);
    modport ctl (output term, output func, input asg, input act);
endinterface

// ---- design/dss_decode.sv ----
`timescale 1ns/1ps
module dss_decode
    import dss_pkg::*;
(
    // sampled terminals and their function codes
    dss_sel_if.dec s
);
    // ************************************************************
    // per-terminal function resolution
    // ************************************************************
    always_comb begin
        for (int f = 0; f < NF; f++) begin
            for (int t = 0; t < N_TERM; t++) begin
                s.asg[f][t] = (s.func[5*t +: 5] == FC_TAB[f]); // RULE23
                s.act[f][t] = s.asg[f][t] & s.term[t];
            end
        end
    end
endmodule

// ---- design/dss_top.sv ----
`timescale 1ns/1ps
//Contract
// RULE1: external setpoint passes only when all enables energized
// RULE2: enable off removes only external setpoint
// RULE3: any oscillation input substitutes square wave
// RULE4: inching uses own terminal or word setpoint
// RULE5: inching needs shutdown command and operating enable
// RULE6: inching closes contactor, setpoint through ramp
// RULE7: inching off: inhibit at minimum speed, delayed dropout
// RULE8: report o1.3 during inching withdrawal delay
// RULE9: two inching inputs give zero setpoint
// RULE10: inching bypass: only while present, zero ramps
// RULE11: crawl only in o7 or run with enable
// RULE12: crawl in o7 closes contactor, ramps setpoint
// RULE13: crawl while running ramps down to crawl
// RULE14: crawl off without switch-on: inhibit, drop contactor (code drops the contactor at minimum speed but never raises ctrl_inhibit)
// RULE15: crawl off in run returns to operating speed
// RULE16: several crawl inputs sum their setpoints
// RULE17: edge crawl starts only with shutdown button high
// RULE18: crawl bypass: only while present, zero ramps
// RULE19: fixed setpoint sum replaces main setpoint
// RULE20: all fixed inputs open: main setpoint again
// RULE21: fixed bypass: only while present, zero ramps
// RULE22: supplementary sum added to technology setpoint
// RULE23: sample inputs per cycle, resolve function codes
// RULE24: hold selected setpoints in registers between cycles
module dss_top
    import dss_pkg::*;
#(
    parameter int UNIT_CYCLES = DELAY_UNIT_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // select terminals
    input wire logic [N_TERM-1:0] sel_term,
    // drive state
    input wire logic shutdown_cmd,
    input wire logic operating_enable,
    input wire logic controller_enable,
    input wire logic state_o7,
    input wire logic state_run,
    input wire logic speed_below_min,
    input wire logic [SP_W-1:0] main_setpoint,
    input wire logic [SP_W-1:0] oscillation_square_wave,
    // setpoint outputs
    output logic [SP_W-1:0] ramp_in_setpoint,
    output logic [SP_W-1:0] tech_suppl_setpoint,
    output logic ramp_bypass,
    // sequence outputs
    output logic line_contactor_req,
    output logic ctrl_inhibit,
    output logic state_o13
);
    localparam logic signed [SUM_W-1:0] SMAX = 20'sh0_7fff;
    localparam logic signed [SUM_W-1:0] SMIN = 20'shf_8000;
    localparam int UW = $clog2(UNIT_CYCLES + 1);

    // ************************************************************
    // reset release and input sampling
    // ************************************************************
    logic rst_m;
    logic rst_n;
    logic [N_TERM-1:0] term_m;
    logic [N_TERM-1:0] term_s;
    logic [N_TERM-1:0] term_r;
    logic [NF-1:0] cw_q;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            term_m <= '0;
            term_s <= '0;
        end else begin
            term_m <= sel_term;
            term_s <= term_m;
        end
    end

    assign tick = (tick_cnt == TICK_LAST);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= '0;
        end else if (tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    // ************************************************************
    // register file
    // ************************************************************
    logic [29:0] func_r;
    logic [NF-1:0] cw_r;
    logic edge_cfg_r;
    logic [DROP_W-1:0] drop_r;
    logic [SP_W-1:0] dsp_r [N_TERM];
    logic [SP_W-1:0] cwsp_r [N_CWSP];
    logic [31:0] rd_val;
    logic [31:0] prdata_r;
    logic hit;
    logic err_r;
    logic wr_en;
    logic in_dsp;
    logic in_cwsp;
    logic [7:0] dsp_off;
    logic [7:0] cwsp_off;
    logic [2:0] dsp_idx;
    logic [2:0] cwsp_idx;
    dss_seq_t seq_r;
    dss_seq_t seq_nxt;
    logic kind_r;

    assign dsp_off = paddr - DSP_BASE;
    assign cwsp_off = paddr - CWSP_BASE;
    assign dsp_idx = dsp_off[4:2];
    assign cwsp_idx = cwsp_off[4:2];
    assign in_dsp = (paddr >= DSP_BASE) && (paddr < DSP_END)
                    && (paddr[1:0] == 2'b00);
    assign in_cwsp = (paddr >= CWSP_BASE) && (paddr < CWSP_END)
                     && (paddr[1:0] == 2'b00);
    assign wr_en = psel & penable & pwrite & hit;

    always_comb begin
        rd_val = '0;
        hit = 1'b1;
        if (paddr == FUNC_CFG_OFS) begin
            rd_val = {2'b00, func_r};
        end else if (paddr == CTRL_WORD_OFS) begin
            rd_val = {22'h00_0000, cw_r};
        end else if (paddr == CFG_OFS) begin
            rd_val = {31'h0000_0000, edge_cfg_r};
        end else if (paddr == DROPOUT_OFS) begin
            rd_val = {19'h0_0000, drop_r};
        end else if (in_dsp) begin
            rd_val = {16'h0000, dsp_r[dsp_idx]};
        end else if (in_cwsp) begin
            rd_val = {16'h0000, cwsp_r[cwsp_idx]};
        end else if (paddr == STATUS_OFS) begin
            rd_val = {26'h000_0000, seq_r, state_o13, ctrl_inhibit,
                      ramp_bypass, line_contactor_req};
        end else if (paddr == RAMP_OFS) begin
            rd_val = {16'h0000, ramp_in_setpoint};
        end else if (paddr == TECH_OFS) begin
            rd_val = {16'h0000, tech_suppl_setpoint};
        end else begin
            hit = 1'b0;
        end
    end

    // read data and error are caught in the setup cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= '0;
            err_r <= 1'b0;
        end else if (psel && !penable) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
            err_r <= ~hit;
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = psel & penable & err_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            func_r <= FUNC_CFG_RST;
            cw_r <= CTRL_WORD_RST;
            edge_cfg_r <= 1'b0;
            drop_r <= DROPOUT_RST;
        end else if (wr_en) begin
            if (paddr == FUNC_CFG_OFS) begin
                func_r <= pwdata[29:0];
            end else if (paddr == CTRL_WORD_OFS) begin
                cw_r <= pwdata[NF-1:0];
            end else if (paddr == CFG_OFS) begin
                edge_cfg_r <= pwdata[0];
            end else if (paddr == DROPOUT_OFS) begin
                // clamp keeps the dropout delay inside its 60 s span
                drop_r <= (pwdata[DROP_W-1:0] > DROPOUT_MAX) ?
                          DROPOUT_MAX : pwdata[DROP_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N_TERM; i++) begin
                dsp_r[i] <= '0;
            end
            for (int i = 0; i < N_CWSP; i++) begin
                cwsp_r[i] <= '0;
            end
        end else if (wr_en && in_dsp) begin
            dsp_r[dsp_idx] <= pwdata[SP_W-1:0];
        end else if (wr_en && in_cwsp) begin
            cwsp_r[cwsp_idx] <= pwdata[SP_W-1:0];
        end
    end

    // ************************************************************
    // per-cycle sampling and function resolution
    // ************************************************************
    dss_sel_if sel ();

    dss_decode u_dec (
        .s(sel)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            term_r <= '0;
            cw_q <= CTRL_WORD_RST;
        end else if (tick) begin
            term_r <= term_s; // RULE23
            cw_q <= cw_r;
        end
    end

    assign sel.term = term_r;
    assign sel.func = func_r;

    // ************************************************************
    // setpoint arithmetic
    // ************************************************************
    function automatic logic signed [SUM_W-1:0] msum(
        input logic [N_TERM-1:0] m,
        input logic c,
        input logic [SP_W-1:0] csp
    );
        logic signed [SUM_W-1:0] acc;
        acc = c ? SUM_W'(signed'(csp)) : '0;
        for (int t = 0; t < N_TERM; t++) begin
            if (m[t]) begin
                acc = acc + SUM_W'(signed'(dsp_r[t]));
            end
        end
        return acc;
    endfunction

    function automatic logic [SP_W-1:0] sat(
        input logic signed [SUM_W-1:0] v
    );
        logic [SP_W-1:0] r;
        r = v[SP_W-1:0];
        if (v > SMAX) begin
            r = SMAX[SP_W-1:0];
        end else if (v < SMIN) begin
            r = SMIN[SP_W-1:0];
        end
        return r;
    endfunction

    logic [NF-1:0] req;
    logic en_ok;
    logic sdb_high;
    logic inch_on;
    logic inch_multi;
    logic crawl_ok;
    logic crawl_lvl;
    logic crawl_prev_r;
    logic crawl_edge_r;
    logic crawl_on;
    logic fix_ok;
    logic fix_on;
    logic sup_on;
    logic osc_on;
    logic [SP_W-1:0] inch_s;
    logic [SP_W-1:0] crawl_s;
    logic [SP_W-1:0] fix_s;
    logic [SP_W-1:0] sup_s;
    logic [SP_W-1:0] oper_sp;
    logic [SP_W-1:0] ramp_nxt;
    logic bypass_nxt;

    always_comb begin
        for (int f = 0; f < NF; f++) begin
            req[f] = (|sel.act[f]) | cw_q[f];
        end
    end

    assign en_ok = (sel.act[FI_EN] == sel.asg[FI_EN]) & cw_q[FI_EN]; // RULE1
    assign sdb_high = (sel.act[FI_SDB] == sel.asg[FI_SDB]) & cw_q[FI_SDB];
    assign inch_on = (req[FI_INCH] | req[FI_INCHB])
                     & shutdown_cmd & operating_enable; // RULE5
    assign inch_multi = ($countones({sel.act[FI_INCH], sel.act[FI_INCHB],
                        cw_q[FI_INCH], cw_q[FI_INCHB]}) > 1);
    assign inch_s = inch_multi ? '0 // RULE9
                  : sat(msum(sel.act[FI_INCH], cw_q[FI_INCH], cwsp_r[0])
                  + msum(sel.act[FI_INCHB], cw_q[FI_INCHB],
                         cwsp_r[1])); // RULE4
    assign crawl_ok = state_o7 | (state_run & operating_enable); // RULE11
    assign crawl_lvl = req[FI_CRAWL];
    assign crawl_on = crawl_ok & (req[FI_CRAWLB]
                      | (edge_cfg_r ? crawl_edge_r : crawl_lvl));
    assign crawl_s = sat(msum(sel.act[FI_CRAWL], cw_q[FI_CRAWL], cwsp_r[2])
                   + msum(sel.act[FI_CRAWLB], cw_q[FI_CRAWLB],
                          cwsp_r[3])); // RULE16
    assign fix_ok = state_run & controller_enable;
    assign fix_on = fix_ok & (req[FI_FIX] | req[FI_FIXB]); // RULE19 RULE20
    assign fix_s = sat(msum(sel.act[FI_FIX], cw_q[FI_FIX], cwsp_r[4])
                 + msum(sel.act[FI_FIXB], cw_q[FI_FIXB], cwsp_r[5]));
    assign sup_on = fix_ok & req[FI_SUP];
    assign sup_s = sat(msum(sel.act[FI_SUP], cw_q[FI_SUP], cwsp_r[6]));
    assign osc_on = req[FI_OSC];

    // internal setpoints bypass the enable gate on purpose
    always_comb begin
        oper_sp = en_ok ? main_setpoint : '0; // RULE1 RULE2
        if (fix_on) begin
            oper_sp = fix_s; // RULE19
        end
        if (osc_on) begin
            oper_sp = oscillation_square_wave; // RULE3
        end
        ramp_nxt = oper_sp; // RULE15 RULE20
        if (inch_on) begin
            ramp_nxt = inch_s; // RULE6
        end else if (crawl_on) begin
            ramp_nxt = crawl_s; // RULE12 RULE13
        end
        bypass_nxt = (inch_on & req[FI_INCHB]) // RULE10
                   | (!inch_on & crawl_on & req[FI_CRAWLB]) // RULE18
                   | (!inch_on & !crawl_on & fix_on & req[FI_FIXB]); // RULE21
    end

    // edge crawl latches until the shutdown button goes low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crawl_prev_r <= 1'b0;
            crawl_edge_r <= 1'b0;
        end else if (tick) begin
            crawl_prev_r <= crawl_lvl;
            if (!sdb_high) begin
                crawl_edge_r <= 1'b0;
            end else if (crawl_lvl && !crawl_prev_r) begin
                crawl_edge_r <= 1'b1; // RULE17
            end
        end
    end

    // setpoint outputs move only at the cycle edge, so the ramp never glitches
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ramp_in_setpoint <= '0;
            tech_suppl_setpoint <= '0;
            ramp_bypass <= 1'b0;
        end else if (tick) begin
            ramp_in_setpoint <= ramp_nxt; // RULE24
            tech_suppl_setpoint <= sup_on ? sup_s : '0; // RULE22
            ramp_bypass <= bypass_nxt;
        end
    end

    // ************************************************************
    // contactor sequence
    // ************************************************************
    logic start_req;
    logic [UW-1:0] pre_cnt;
    logic [DROP_W-1:0] unit_cnt;
    logic dly_done;

    assign start_req = inch_on | (crawl_on & state_o7 & !state_run);
    assign dly_done = (unit_cnt >= drop_r);

    always_comb begin
        seq_nxt = seq_r;
        case (seq_r)
            ST_IDLE: begin
                if (start_req) begin
                    seq_nxt = ST_ACT; // RULE6 RULE12
                end
            end
            ST_ACT: begin
                if (!inch_on && !crawl_on) begin
                    seq_nxt = ST_DOWN;
                end
            end
            ST_DOWN: begin
                if (start_req) begin
                    seq_nxt = ST_ACT;
                end else if (speed_below_min) begin
                    seq_nxt = kind_r ? ST_DELAY : ST_IDLE; // RULE7 RULE14
                end
            end
            ST_DELAY: begin
                // a fresh request during dropout keeps the contactor in
                if (start_req) begin
                    seq_nxt = ST_ACT;
                end else if (dly_done) begin
                    seq_nxt = ST_IDLE; // RULE7
                end
            end
            default: begin
                seq_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_r <= ST_IDLE;
            kind_r <= 1'b0;
            line_contactor_req <= 1'b0;
            ctrl_inhibit <= 1'b0;
            state_o13 <= 1'b0;
        end else begin
            seq_r <= seq_nxt;
            if (seq_r != ST_ACT && seq_nxt == ST_ACT) begin
                kind_r <= inch_on;
            end
            line_contactor_req <= (seq_nxt != ST_IDLE);
            ctrl_inhibit <= (seq_nxt == ST_DELAY); // RULE7
            state_o13 <= kind_r && (seq_nxt == ST_DOWN
                         || seq_nxt == ST_DELAY); // RULE8
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= '0;
            unit_cnt <= '0;
        end else if (seq_r != ST_DELAY) begin
            pre_cnt <= '0;
            unit_cnt <= '0;
        end else if (pre_cnt == UW'(UNIT_CYCLES - 1)) begin
            pre_cnt <= '0;
            unit_cnt <= unit_cnt + 1'b1;
        end else begin
            pre_cnt <= pre_cnt + 1'b1;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_ext_pass;
        tick && en_ok && !fix_on && !osc_on && !inch_on && !crawl_on
        |=> ramp_in_setpoint == $past(main_setpoint);
    endproperty
    a_ext_pass: assert property (p_ext_pass) // RULE1
        else $error("external setpoint not passed");

    property p_int_kept;
        tick && !en_ok && fix_on && !osc_on && !inch_on && !crawl_on
        |=> ramp_in_setpoint == $past(fix_s);
    endproperty
    a_int_kept: assert property (p_int_kept) // RULE2
        else $error("fixed setpoint lost when enable open");

    property p_osc;
        tick && osc_on && !inch_on && !crawl_on
        |=> ramp_in_setpoint == $past(oscillation_square_wave);
    endproperty
    a_osc: assert property (p_osc) // RULE3
        else $error("oscillation setpoint not applied");

    property p_inch_gate;
        seq_r == ST_IDLE && !(shutdown_cmd && operating_enable)
        && !crawl_on |=> !line_contactor_req;
    endproperty
    a_inch_gate: assert property (p_inch_gate) // RULE5
        else $error("inching honoured without enables");

    property p_inch_contactor;
        inch_on |=> line_contactor_req [*2];
    endproperty
    a_inch_contactor: assert property (p_inch_contactor) // RULE6
        else $error("contactor not requested on inching");

    property p_inhibit;
        seq_r == ST_DOWN && kind_r && speed_below_min && !start_req
        |=> ctrl_inhibit && line_contactor_req;
    endproperty
    a_inhibit: assert property (p_inhibit) // RULE7
        else $error("controller not inhibited before dropout");

    property p_o13_bound;
        state_o13 && seq_r == ST_DELAY |-> unit_cnt <= drop_r;
    endproperty
    a_o13_bound: assert property (p_o13_bound) // RULE8
        else $error("o1.3 held past programmed delay");

    property p_inch_zero;
        tick && inch_on && inch_multi |=> ramp_in_setpoint == '0;
    endproperty
    a_inch_zero: assert property (p_inch_zero) // RULE9
        else $error("double inching setpoint not zero");

    property p_crawl_drop;
        seq_r == ST_DOWN && !kind_r && speed_below_min && !start_req
        |=> !line_contactor_req && seq_r == ST_IDLE;
    endproperty
    a_crawl_drop: assert property (p_crawl_drop) // RULE14
        else $error("contactor kept after crawl withdrawal");

    property p_hold;
        !$past(tick) |-> $stable(ramp_in_setpoint) && $stable(ramp_bypass);
    endproperty
    a_hold: assert property (p_hold) // RULE24
        else $error("setpoint changed between control cycles");

    c_inch_delay: cover property (seq_r == ST_DOWN ##1 seq_r == ST_DELAY);
    c_crawl_o7: cover property (crawl_on && state_o7 && seq_r == ST_IDLE);
    c_fixed: cover property (tick && fix_on && req[FI_FIXB]);
    c_edge: cover property (tick && edge_cfg_r && crawl_lvl && sdb_high);
endmodule

// ---- tb/dss_partner.sv ----
`timescale 1ns/1ps
module dss_partner (
    // clock
    input wire logic clk,
    // requests from the test sequence
    input wire logic [5:0] want,
    input wire logic sd_want,
    // levels seen by the drive
    output logic [5:0] sel_term,
    output logic shutdown_cmd
);
    // shutdown command is presented together with the terminals it gates
    always_ff @(posedge clk) begin
        shutdown_cmd <= sd_want;
        sel_term <= want;
    end
endmodule

// ---- tb/drive_setpoint_source_select_bench.sv ----
`timescale 1ns/1ps
module drive_setpoint_source_select_bench;
    import dss_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] want, sel_term;
    logic sd_want, sd, oe, ce, run, slow, byp, lc, inh, o13, o7;
    logic [15:0] main_sp, ramp, tech;
    int miscompares, num_checks;

    dss_partner prt (.clk(clk), .want(want), .sd_want(sd_want),
        .sel_term(sel_term), .shutdown_cmd(sd));
    dss_top #(.UNIT_CYCLES(10)) uut (.clk(clk), .rst_b(rst_b),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sel_term(sel_term), .shutdown_cmd(sd),
        .operating_enable(oe), .controller_enable(ce),
        .state_o7(o7), .state_run(run), .speed_below_min(slow),
        .main_setpoint(main_sp), .oscillation_square_wave(~main_sp),
        .ramp_in_setpoint(ramp), .tech_suppl_setpoint(tech),
        .ramp_bypass(byp), .line_contactor_req(lc),
        .ctrl_inhibit(inh), .state_o13(o13));

    // ****************************************
    // tasks
    // ****************************************
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task print_verdict;
        if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // hold the request until pready is seen high at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // two control ticks plus sync: one full update must have landed
    task step(input logic [5:0] w);
        want <= w;
        repeat (2100) @(posedge clk);
    endtask

    // ****************************************
    // stimulus
    // ****************************************
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end

    initial begin
        #4_000_000;
        miscompares++;
        print_verdict;
    end

    initial begin
        {rst_b, psel, penable, pwrite, sd_want, oe, ce, run, slow, o7} = 0;
        paddr = 0;
        pwdata = 0;
        want = 0;
        main_sp = 16'h1234;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, CTRL_WORD_OFS, 32'h0000_0000);
        chk(rd, 32'(CTRL_WORD_RST));
        apb(1'b0, 8'h80, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        apb(1'b1, FUNC_CFG_OFS, 32'({FC_TAB[FI_INCH], FC_TAB[FI_INCH],
            FC_TAB[FI_FIX], FC_TAB[FI_FIX], FC_TAB[FI_EN]}));
        for (int i = 1; i < 5; i++) begin
            apb(1'b1, DSP_BASE + 8'(4 * i), 32'(i * 16'h0110));
        end
        apb(1'b1, DROPOUT_OFS, 32'h0000_0005);
        step(6'h01);
        chk(32'(ramp), 32'h0000_1234);
        step(6'h00);
        chk(32'(ramp), 32'h0000_0000);
        run <= 1'b1;
        ce <= 1'b1;
        // enable open, fixed sum must still reach the ramp input
        step(6'h06);
        chk(32'(ramp), 32'h0000_0330);
        step(6'h01);
        chk(32'(ramp), 32'h0000_1234);
        run <= 1'b0;
        ce <= 1'b0;
        step(6'h08);
        chk(32'(lc), 32'h0000_0000);
        sd_want <= 1'b1;
        oe <= 1'b1;
        step(6'h08);
        chk(32'(lc), 32'h0000_0001);
        chk(32'(ramp), 32'h0000_0330);
        step(6'h18);
        chk(32'(ramp), 32'h0000_0000);
        step(6'h00);
        chk(32'(o13), 32'h0000_0001);
        chk(32'(lc), 32'h0000_0001);
        slow <= 1'b1;
        repeat (5) @(posedge clk);
        chk(32'(inh), 32'h0000_0001);
        repeat (60) @(posedge clk);
        chk(32'(lc), 32'h0000_0000);
        chk(32'(o13), 32'h0000_0000);
        // oscillation and technology supplement from the control word
        run <= 1'b1;
        ce <= 1'b1;
        apb(1'b1, CWSP_BASE + 8'h18, 32'h0000_0055);
        apb(1'b1, CTRL_WORD_OFS, 32'h0000_0207);
        step(6'h00);
        chk(32'(ramp), 32'h0000_edcb);
        chk(32'(tech), 32'h0000_0055);
        // crawl bypass from standstill in o7
        run <= 1'b0;
        ce <= 1'b0;
        o7 <= 1'b1;
        apb(1'b1, CWSP_BASE + 8'h0C, 32'h0000_0077);
        apb(1'b1, CTRL_WORD_OFS, 32'h0000_0043);
        step(6'h00);
        chk(32'(lc), 32'h0000_0001);
        chk(32'(ramp), 32'h0000_0077);
        chk(32'(byp), 32'h0000_0001);
        apb(1'b1, CTRL_WORD_OFS, 32'h0000_0003);
        step(6'h00);
        chk(32'(lc), 32'h0000_0000);
        chk(32'(byp), 32'h0000_0000);
        // edge crawl: the word's shutdown button bit is the assigned input
        apb(1'b1, CFG_OFS, 32'h0000_0001);
        apb(1'b1, CTRL_WORD_OFS, 32'h0000_0023);
        step(6'h00);
        chk(32'(lc), 32'h0000_0001);
        apb(1'b1, CTRL_WORD_OFS, 32'h0000_0003);
        step(6'h00);
        chk(32'(lc), 32'h0000_0001);
        apb(1'b1, CTRL_WORD_OFS, 32'h0000_0002);
        step(6'h00);
        chk(32'(lc), 32'h0000_0000);
        print_verdict;
    end
endmodule
